// file: hdl/ddcsc_top.sv
// Downconverter channel zero control, sync logic and output buffer
// What this block does
// - One-shot mode realigns oscillator on first valid sysref edge only, ignores later ones.
// - Sync enable at zero or sysref input disabled: no realignment at all.
// - One-shot mode clears sync enable itself when the arming edge arrives.
// - Next-sync zero realigns on every edge; sysref period must fit oscillator.
// - Soft reset bit holds oscillator phase and decimation count at zero and drops input samples; zero runs normally.
// - Mixer bit zero takes I and Q from one real channel; one is complex.
// - Gain bit one doubles the downconverted output, zero leaves unity gain.
// - Complex-to-real bit one outputs real I only via extra quarter-rate mix.
// - Chain code 11: first stage only, decimate 1 real or 2 complex.
// - Chain code 00: stages two and one, decimate 2 real or 4 complex.
// - Chain code 01: stages three to one, decimate 4 real or 8 complex.
// - Chain code 10: all four stages, decimate 8 real or 16 complex.
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "ddcsc_map.svh"
module ddcsc_top
    import ddcsc_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [`DDCSC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [`DDCSC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Sync reference
    input wire logic sysref_in,
    input wire logic sysref_input_enable,
    // Samples from converter cores
    input wire ddcsc_pkg::ddcsc_sample_s in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Samples to framer
    output ddcsc_pkg::ddcsc_sample_s out_data,
    output logic out_valid,
    input wire logic out_ready
);
    import ddcsc_pkg::*;

    function automatic ddcsc_word_t sat2(input ddcsc_word_t x);
        if (x[`DDCSC_SAMPLE_W-1] != x[`DDCSC_SAMPLE_W-2]) begin
            return x[`DDCSC_SAMPLE_W-1] ? {1'b1, {(`DDCSC_SAMPLE_W-1){1'b0}}}
                                        : {1'b0, {(`DDCSC_SAMPLE_W-1){1'b1}}};
        end
        return ddcsc_word_t'(x <<< 1);
    endfunction : sat2

    // Quarter-rate rotation by phase step p
    function automatic ddcsc_sample_s rot4(input ddcsc_sample_s s, input logic [1:0] p);
        ddcsc_sample_s r;
        r = s;
        unique case (p)
            2'd0: r = s;
            2'd1: r = '{i: s.q, q: -s.i};
            2'd2: r = '{i: -s.i, q: -s.q};
            2'd3: r = '{i: -s.q, q: s.i};
        endcase
        return r;
    endfunction : rot4

    function automatic logic [4:0] dec_factor(input logic [1:0] sel, input logic c2r);
        logic [4:0] f;
        f = 5'h01;
        unique case (sel)
            2'b11: f = 5'h01;
            2'b00: f = 5'h02;
            2'b01: f = 5'h04;
            2'b10: f = 5'h08;
        endcase
        return c2r ? f : 5'(f << 1);
    endfunction : dec_factor

    // Register state
    logic sync_en, next_sync_en;
    logic one_shot_sync_select, next_one_shot;
    logic downconverter_soft_reset, next_soft_rst;
    ddcsc_ctrl_s ctrl, next_ctrl;
    logic [7:0] sync_count, next_sync_count;
    // Bus state
    logic aw_full, next_aw_full, w_full, next_w_full;
    logic [`DDCSC_ADDR_W-1:0] aw_addr, next_aw_addr;
    logic [7:0] w_byte, next_w_byte;
    logic w_lane, next_w_lane;
    logic next_awready, next_wready, next_arready, next_bvalid, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    // Datapath state
    logic sysref_d, next_sysref_d;
    logic [1:0] osc_phase, next_osc_phase;
    logic [4:0] dec_cnt, next_dec_cnt;
    ddcsc_sample_s skid, next_skid, next_out_data;
    logic skid_valid, next_skid_valid, next_out_valid, next_in_ready;
    // Combinational helpers
    logic do_write, wr_sync, realign, in_fire, keep, push, pop;
    logic [4:0] factor;
    ddcsc_sample_s mixed, shifted, gained, wr_data;

    assign do_write = aw_full && w_full && !s_axi_bvalid;
    assign wr_sync = do_write && w_lane && aw_addr == `DDCSC_SYNC_CTRL_OFS;
    // Edge counts only when both sysref and sync enable are on
    assign realign = sysref_in && !sysref_d && sysref_input_enable && sync_en;
    assign in_fire = in_valid && in_ready;
    assign factor = dec_factor(ctrl.decimation_chain_select,
                               ctrl.real_output_convert_enable);
    assign keep = dec_cnt == 5'h00;
    assign push = in_fire && keep && !downconverter_soft_reset;
    assign pop = out_valid && out_ready;

    always_comb begin
        mixed = in_data;
        if (!ctrl.mixer_type_select) begin
            mixed.q = in_data.i;
        end
        unique case (ddcsc_if_e'(ctrl.intermediate_freq_mode))
            DDCSC_IF_QUARTER: shifted = rot4(mixed, osc_phase);
            DDCSC_IF_TEST: shifted = '{i: `DDCSC_TEST_PATTERN, q: ~`DDCSC_TEST_PATTERN};
            default: shifted = mixed;
        endcase
        gained = shifted;
        if (ctrl.six_db_gain_select) begin
            gained = '{i: sat2(shifted.i), q: sat2(shifted.q)};
        end
        wr_data = gained;
        if (ctrl.real_output_convert_enable) begin
            wr_data = rot4(gained, osc_phase);
            wr_data.q = '0;
        end
    end

    always_comb begin
        next_sync_en = sync_en;
        next_one_shot = one_shot_sync_select;
        next_soft_rst = downconverter_soft_reset;
        next_ctrl = ctrl;
        next_sync_count = sync_count;
        if (realign) begin
            next_sync_count = sync_count + 8'h01;
        end
        if (realign && one_shot_sync_select) begin
            next_sync_en = 1'b0;
        end
        if (wr_sync) begin
            next_sync_en = w_byte[`DDCSC_SYNC_EN_BIT];
            next_one_shot = w_byte[`DDCSC_NEXT_SYNC_BIT];
            next_soft_rst = w_byte[`DDCSC_SOFT_RST_BIT];
        end
        if (do_write && w_lane && aw_addr == `DDCSC_DDC0_CTRL_OFS) begin
            next_ctrl = '{w_byte[`DDCSC_MIX_BIT], w_byte[`DDCSC_GAIN_BIT],
                          w_byte[`DDCSC_IF_MSB:`DDCSC_IF_LSB], w_byte[`DDCSC_C2R_BIT],
                          w_byte[`DDCSC_DEC_MSB:`DDCSC_DEC_LSB]};
        end
    end

    always_comb begin
        next_aw_full = aw_full;
        next_aw_addr = aw_addr;
        next_w_full = w_full;
        next_w_byte = w_byte;
        next_w_lane = w_lane;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_full = 1'b1;
            next_aw_addr = {s_axi_awaddr[`DDCSC_ADDR_W-1:2], 2'b00};
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_full = 1'b1;
            next_w_byte = s_axi_wdata[7:0];
            next_w_lane = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (do_write) begin
            next_aw_full = 1'b0;
            next_w_full = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = (aw_addr == `DDCSC_SYNC_CTRL_OFS || aw_addr == `DDCSC_DDC0_CTRL_OFS)
                       ? `DDCSC_RESP_OKAY : `DDCSC_RESP_SLVERR;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = `DDCSC_RESP_OKAY;
            unique case ({s_axi_araddr[`DDCSC_ADDR_W-1:2], 2'b00})
                `DDCSC_SYNC_CTRL_OFS: next_rdata = {27'h0, downconverter_soft_reset,
                                                    2'b00, one_shot_sync_select, sync_en};
                `DDCSC_DDC0_CTRL_OFS: next_rdata = {24'h0, ctrl[6:2], 1'b0, ctrl[1:0]};
                `DDCSC_STATUS_OFS: next_rdata = {19'h0, factor, sync_count};
                default: begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = `DDCSC_RESP_SLVERR;
                end
            endcase
        end
        next_awready = !next_aw_full;
        next_wready = !next_w_full;
        next_arready = !next_rvalid;
    end

    always_comb begin
        next_sysref_d = sysref_in;
        next_osc_phase = osc_phase;
        next_dec_cnt = dec_cnt;
        if (in_fire) begin
            next_osc_phase = osc_phase + 2'd1;
            next_dec_cnt = (dec_cnt >= factor - 5'h01) ? 5'h00 : dec_cnt + 5'h01;
        end
        // Realign on every edge in continuous mode
        if (realign || downconverter_soft_reset) begin
            next_osc_phase = 2'd0;
            next_dec_cnt = 5'h00;
        end
        next_out_data = out_data;
        next_out_valid = out_valid;
        next_skid = skid;
        next_skid_valid = skid_valid;
        if (pop) begin
            next_out_data = skid;
            next_out_valid = skid_valid;
            next_skid_valid = 1'b0;
        end
        // Second slot absorbs one word while the framer stalls
        if (push && !next_out_valid) begin
            next_out_data = wr_data;
            next_out_valid = 1'b1;
        end else if (push) begin
            next_skid = wr_data;
            next_skid_valid = 1'b1;
        end
        next_in_ready = !next_skid_valid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_en <= 1'(`DDCSC_SYNC_CTRL_RST >> `DDCSC_SYNC_EN_BIT);
            one_shot_sync_select <= 1'b0;
            downconverter_soft_reset <= 1'b0;
            // Reserved bit 2 is squeezed out of the stored copy
            ctrl <= ddcsc_ctrl_s'(7'((`DDCSC_DDC0_CTRL_RST >> 1) & 8'h7C
                                     | `DDCSC_DDC0_CTRL_RST & 8'h03));
            sync_count <= 8'h00;
            aw_full <= 1'b0;
            aw_addr <= '0;
            w_full <= 1'b0;
            w_byte <= 8'h00;
            w_lane <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_arready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h0000_0000;
            sysref_d <= 1'b0;
            osc_phase <= 2'd0;
            dec_cnt <= 5'h00;
            out_data <= '0;
            out_valid <= 1'b0;
            skid <= '0;
            skid_valid <= 1'b0;
            in_ready <= 1'b1;
        end else begin
            sync_en <= next_sync_en;
            one_shot_sync_select <= next_one_shot;
            downconverter_soft_reset <= next_soft_rst;
            ctrl <= next_ctrl;
            sync_count <= next_sync_count;
            aw_full <= next_aw_full;
            aw_addr <= next_aw_addr;
            w_full <= next_w_full;
            w_byte <= next_w_byte;
            w_lane <= next_w_lane;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_arready <= next_arready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
            sysref_d <= next_sysref_d;
            osc_phase <= next_osc_phase;
            dec_cnt <= next_dec_cnt;
            out_data <= next_out_data;
            out_valid <= next_out_valid;
            skid <= next_skid;
            skid_valid <= next_skid_valid;
            in_ready <= next_in_ready;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    oneshot_clear_a: assert property (realign && one_shot_sync_select && !wr_sync
        |=> !sync_en ##1 !realign) else $error("one-shot sync not disarmed");
    oneshot_ignore_a: assert property (one_shot_sync_select && !sync_en && !wr_sync
        |=> !realign) else $error("edge used after one-shot");
    sync_off_a: assert property (!sync_en || !sysref_input_enable
        |-> $past(sync_count) == sync_count || !$past(aresetn) || $past(realign))
        else $error("sync counted while disabled");
    realign_phase_a: assert property (realign && !in_fire && !one_shot_sync_select
        |=> osc_phase == 2'd0 && dec_cnt == 5'h00 && sync_en)
        else $error("continuous realign wrong");
    soft_rst_hold_a: assert property (downconverter_soft_reset
        |-> !push ##1 (osc_phase == 2'd0)) else $error("soft reset not holding");
    mix_real_a: assert property (push && !ctrl.mixer_type_select
        && !ctrl.intermediate_freq_mode[1] && !ctrl.six_db_gain_select
        && !ctrl.real_output_convert_enable
        |-> wr_data.q == in_data.i && wr_data.i == in_data.i) else $error("real mixer wrong");
    gain_double_a: assert property (push && ctrl.six_db_gain_select
        && shifted.i[15] == shifted.i[14] |-> gained.i == {shifted.i[14:0], 1'b0})
        else $error("gain wrong");
    test_mode_a: assert property (push && ctrl.intermediate_freq_mode == 2'b11
        && !ctrl.six_db_gain_select && !ctrl.real_output_convert_enable
        |-> wr_data.i == `DDCSC_TEST_PATTERN) else $error("test mode pattern wrong");
    real_only_a: assert property (push && ctrl.real_output_convert_enable
        |-> wr_data.q == '0) else $error("real output has Q");
    dec_one_a: assert property (ctrl.decimation_chain_select == 2'b11
        |-> factor == (ctrl.real_output_convert_enable ? 5'd1 : 5'd2))
        else $error("chain 11 factor");
    dec_two_a: assert property (ctrl.decimation_chain_select == 2'b00
        |-> factor == (ctrl.real_output_convert_enable ? 5'd2 : 5'd4))
        else $error("chain 00 factor");
    dec_four_a: assert property (ctrl.decimation_chain_select == 2'b01
        |-> factor == (ctrl.real_output_convert_enable ? 5'd4 : 5'd8))
        else $error("chain 01 factor");
    dec_eight_a: assert property (ctrl.decimation_chain_select == 2'b10
        |-> factor == (ctrl.real_output_convert_enable ? 5'd8 : 5'd16))
        else $error("chain 10 factor");
    dec_gap_a: assert property (push && factor == 5'd2 && !realign && !downconverter_soft_reset
        |=> !push) else $error("decimation gap");

    oneshot_c: cover property (realign && one_shot_sync_select);
    stall_c: cover property (!in_ready && in_valid);
    test_c: cover property (push && ctrl.intermediate_freq_mode == 2'b11);
    dec16_c: cover property (push && factor == 5'd16);
endmodule : ddcsc_top

// file: include/ddcsc_map.svh
// Register offsets, field positions, reset values and constants
`ifndef DDCSC_MAP_SVH
`define DDCSC_MAP_SVH
`define DDCSC_ADDR_W 12
`define DDCSC_SAMPLE_W 16
`define DDCSC_SYNC_CTRL_OFS 12'h300
`define DDCSC_DDC0_CTRL_OFS 12'h310
`define DDCSC_STATUS_OFS 12'h3F0
`define DDCSC_SYNC_EN_BIT 0
`define DDCSC_NEXT_SYNC_BIT 1
`define DDCSC_SOFT_RST_BIT 4
`define DDCSC_MIX_BIT 7
`define DDCSC_GAIN_BIT 6
`define DDCSC_IF_MSB 5
`define DDCSC_IF_LSB 4
`define DDCSC_C2R_BIT 3
`define DDCSC_DEC_MSB 1
`define DDCSC_DEC_LSB 0
`define DDCSC_SYNC_CTRL_RST 8'h00
`define DDCSC_DDC0_CTRL_RST 8'h00
`define DDCSC_TEST_PATTERN 16'h5A5A
`define DDCSC_RESP_OKAY 2'h0
`define DDCSC_RESP_SLVERR 2'h2
`endif

// file: include/ddcsc_pkg.sv
// Types shared by the downconverter control block
`include "ddcsc_map.svh"
package ddcsc_pkg;
    typedef logic signed [`DDCSC_SAMPLE_W-1:0] ddcsc_word_t;
    typedef struct packed {
        ddcsc_word_t i;
        ddcsc_word_t q;
    } ddcsc_sample_s;
    typedef struct packed {
        logic mixer_type_select;
        logic six_db_gain_select;
        logic [1:0] intermediate_freq_mode;
        logic real_output_convert_enable;
        logic [1:0] decimation_chain_select;
    } ddcsc_ctrl_s;
    typedef enum logic [1:0] {
        DDCSC_IF_VARIABLE,
        DDCSC_IF_ZERO,
        DDCSC_IF_QUARTER,
        DDCSC_IF_TEST
    } ddcsc_if_e;
endpackage : ddcsc_pkg

// file: bench/ddcsc_far_side.sv
// Far-side model: converter sample source and framer sink
`timescale 1ns/1ns
module ddcsc_far_side
    import ddcsc_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bench control
    input wire ddcsc_pkg::ddcsc_sample_s src_sample,
    input wire logic [7:0] src_count,
    input wire logic src_start,
    input wire logic [1:0] sink_mode,
    // Design stream ports
    output ddcsc_pkg::ddcsc_sample_s in_data = '0,
    output logic in_valid = 1'b0,
    input wire logic in_ready,
    input wire ddcsc_pkg::ddcsc_sample_s out_data,
    input wire logic out_valid,
    output logic out_ready = 1'b0
);
    logic [7:0] left = 8'h00;
    logic [1:0] cyc = 2'h0;
    ddcsc_sample_s rx_q[$];
    always @(posedge aclk) begin
        logic [7:0] n;
        n = src_start ? src_count : left;
        if (in_valid && in_ready)
            n = n - 8'h01;
        left <= n;
        in_valid <= aresetn && n != 8'h00;
        // Idle line flips every cycle, so a stale word shows as its inverse only on alternate idle cycles
        in_data <= (aresetn && n != 8'h00) ? src_sample : ~in_data;
        cyc <= cyc + 2'h1;
        // Mode 1 stalls three cycles in four, mode 2 never takes
        out_ready <= sink_mode == 2'h0 || (sink_mode == 2'h1 && cyc == 2'h0);
        if (out_valid && out_ready)
            rx_q.push_back(out_data);
    end
endmodule : ddcsc_far_side

// file: bench/ddcsc_top_bench.sv
// Self-checking bench: registers, sync modes, decimation and datapath
`timescale 1ns/1ns
module ddcsc_top_bench;
    import ddcsc_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = '0;
    logic [11:0] s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [31:0] s_axi_rdata, rd;
    logic sysref_in = 1'b0, sysref_input_enable = 1'b0, src_start = 1'b0;
    ddcsc_sample_s in_data, out_data;
    ddcsc_sample_s src_sample = 32'h0123_0456;
    logic in_valid, in_ready, out_valid, out_ready;
    logic [7:0] src_count = 8'h00;
    logic [1:0] sink_mode = 2'h0;
    int bad_count = 0, tests_run = 0, cycles = 0;
    int base [4] = '{2, 4, 8, 1};

    ddcsc_top ddcsc_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sysref_in, .sysref_input_enable,
        .in_data, .in_valid, .in_ready, .out_data, .out_valid, .out_ready);
    ddcsc_far_side ddcsc_far_side_inst (.aclk, .aresetn, .src_sample, .src_count, .src_start,
        .sink_mode, .in_data, .in_valid, .in_ready, .out_data, .out_valid, .out_ready);

    initial forever #10 aclk = ~aclk;

    task tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    // Whole run needs well under this many cycles
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        check(32'(s_axi_bresp), 32'(er));
    endtask : axi_write

    task axi_read(input logic [11:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_read

    task rd_check(input logic [11:0] a, input logic [31:0] e);
        axi_read(a);
        check(rd, e);
        check(32'(rs), 32'h0000_0000);
    endtask : rd_check

    task cnt_check(input logic [31:0] e);
        axi_read(12'h3F0);
        check(32'(rd[7:0]), e);
    endtask : cnt_check

    task pulse;
        @(posedge aclk) sysref_in <= 1'b1;
        @(posedge aclk) sysref_in <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask : pulse

    // Soft reset pulse restarts phase and decimation count from zero
    task setup(input logic [7:0] ctrl);
        axi_write(12'h310, {24'h0, ctrl}, 2'h0);
        axi_write(12'h300, 32'h0000_0010, 2'h0);
        axi_write(12'h300, 32'h0000_0000, 2'h0);
        ddcsc_far_side_inst.rx_q.delete();
    endtask : setup

    task send(input logic [7:0] n);
        @(posedge aclk);
        src_count <= n;
        src_start <= 1'b1;
        @(posedge aclk) src_start <= 1'b0;
    endtask : send

    task wait_rx(input int n);
        while (ddcsc_far_side_inst.rx_q.size() < n)
            @(posedge aclk);
        repeat (8) @(posedge aclk);
        check(32'(ddcsc_far_side_inst.rx_q.size()), 32'(n));
    endtask : wait_rx

    task run_case(input logic [7:0] ctrl, input logic [31:0] e0, input logic [31:0] e1);
        setup(ctrl);
        send(8'h02);
        wait_rx(ctrl[3] ? 2 : 1);
        check(ddcsc_far_side_inst.rx_q[0], e0);
        if (ctrl[3])
            check(ddcsc_far_side_inst.rx_q[1], e1);
    endtask : run_case

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd_check(12'h300, 32'h0000_0000);
        rd_check(12'h310, 32'h0000_0000);
        axi_read(12'h200);
        check({rd[29:0], rs}, 32'h0000_0002);
        axi_write(12'h204, 32'h0000_00FF, 2'h2);
        axi_write(12'h310, 32'h0000_00FF, 2'h0);
        rd_check(12'h310, 32'h0000_00FB);
        // Lane zero strobe off: the write is dropped
        s_axi_wstrb <= 4'hE;
        axi_write(12'h310, 32'h0000_0000, 2'h0);
        rd_check(12'h310, 32'h0000_00FB);
        s_axi_wstrb <= 4'hF;
        for (int c = 0; c < 8; c++) begin
            axi_write(12'h310, 32'((c & 4) * 2 + (c & 3)), 2'h0);
            axi_read(12'h3F0);
            check(32'(rd[12:8]), 32'((c & 4) ? base[c & 3] : 2 * base[c & 3]));
        end
        sysref_input_enable <= 1'b1;
        pulse();
        cnt_check(32'h0000_0000);
        axi_write(12'h300, 32'h0000_0001, 2'h0);
        sysref_input_enable <= 1'b0;
        pulse();
        cnt_check(32'h0000_0000);
        sysref_input_enable <= 1'b1;
        repeat (3) pulse();
        cnt_check(32'h0000_0003);
        rd_check(12'h300, 32'h0000_0001);
        axi_write(12'h300, 32'h0000_0003, 2'h0);
        repeat (2) pulse();
        cnt_check(32'h0000_0004);
        rd_check(12'h300, 32'h0000_0002);
        setup(8'h8B);
        axi_write(12'h300, 32'h0000_0010, 2'h0);
        send(8'h04);
        repeat (30) @(posedge aclk);
        check(32'(ddcsc_far_side_inst.rx_q.size()), 32'h0000_0000);
        run_case(8'h83, 32'h0123_0456, 32'h0);
        run_case(8'h03, 32'h0123_0123, 32'h0);
        run_case(8'hC3, 32'h0246_08AC, 32'h0);
        run_case(8'h93, 32'h0123_0456, 32'h0);
        run_case(8'hB3, 32'h5A5A_A5A5, 32'h0);
        run_case(8'h8B, 32'h0123_0000, 32'h0456_0000);
        run_case(8'hAB, 32'h0123_0000, 32'hFEDD_0000);
        // Seventeen samples at factor sixteen keep only the first and the last
        setup(8'h82);
        send(8'h11);
        wait_rx(2);
        check(ddcsc_far_side_inst.rx_q[1], 32'h0123_0456);
        // Framer refuses everything: the buffer must fill and push back
        setup(8'h8B);
        sink_mode <= 2'h2;
        send(8'h06);
        repeat (30) @(posedge aclk);
        check(32'(in_ready), 32'h0000_0000);
        sink_mode <= 2'h1;
        wait_rx(6);
        check(ddcsc_far_side_inst.rx_q[5], 32'h0456_0000);
        tally_and_finish();
    end
endmodule : ddcsc_top_bench
